// ===== logic/mpo_pkg.sv
// Package with constants for the meter pulse output unit
// Contract
// - Two independent pulse outputs, first and second, on the communication module.
// - Each output repeats increments of heat, cooling or volume counter.
// - Meter type fixes default sources: heat/vol, heat/cool, cool/vol, vol/vol.
// - Source assignment follows meter type only; not changeable after delivery. Codes 73, 82, 83 force volume on the first output.
// - Pulse weight is one least significant displayed digit of the source; codes 73 and 83 make it four volume steps on the first output.
// - Pulse duration code selects duration; defaults to 95.
// - Codes 73, 82, 83 give volume divider modes on first output.
// - Code 95 gives 32 ms pulses, code 96 gives 100 ms pulses.
// - Code 99 stops counter pulses; outputs follow control commands only.
// - Controlled mode: OFF opens the output, ON closes it.
// - Present state of each output is readable through registers.
// - Every controlled state change is stored; restored after power-on reset.
package mpo_pkg;
	localparam int CLK_MHZ = 250;
	localparam logic [7:0] PDC_V4_5MS = 8'h49;
	localparam logic [7:0] PDC_V1_3MS9 = 8'h52;
	localparam logic [7:0] PDC_V4_22MS = 8'h53;
	localparam logic [7:0] PDC_32MS = 8'h5F;
	localparam logic [7:0] PDC_100MS = 8'h60;
	localparam logic [7:0] PDC_CTRL = 8'h63;
	localparam logic [7:0] PDC_RESET = PDC_32MS;
	// Durations in microseconds
	localparam int T5_US = 5000;
	localparam int T3M9_US = 3900;
	localparam int T22_US = 22000;
	localparam int T32_US = 32000;
	localparam int T100_US = 100000;
	localparam logic [31:0] CYC_5MS = 32'(T5_US * CLK_MHZ);
	localparam logic [31:0] CYC_3M9 = 32'(T3M9_US * CLK_MHZ);
	localparam logic [31:0] CYC_22MS = 32'(T22_US * CLK_MHZ);
	localparam logic [31:0] CYC_32MS = 32'(T32_US * CLK_MHZ);
	localparam logic [31:0] CYC_100MS = 32'(T100_US * CLK_MHZ);
	localparam logic [1:0] DIV_VOL4 = 2'h3;
	// Register byte addresses
	localparam logic [3:0] ADDR_CODE = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam logic [3:0] ADDR_TYPE = 4'hC;
	localparam logic [31:0] RD_UNMAPPED = 32'hDEADBEEF;
	typedef enum logic [1:0] {
		MPO_SRC_HEAT = 2'b00,
		MPO_SRC_COOL = 2'b01,
		MPO_SRC_VOL = 2'b10
	} mpo_src_t;
	typedef enum logic [1:0] {
		MPO_IDLE = 2'b00,
		MPO_ON = 2'b01,
		MPO_GAP = 2'b10
	} mpo_state_t;
endpackage

// ===== logic/mpo_channel.sv
// One pulse output channel: queues increments and emits timed closed pulses
module mpo_channel
	import mpo_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic incr,
	input wire logic [1:0] divMask,
	input wire logic [31:0] pulseCycles,
	input wire logic enable,
	output logic pulseOn
);
	mpo_state_t state_reg;
	logic [31:0] timer_reg;
	logic [15:0] pend_reg;
	logic [1:0] div_reg;
	logic divHit;
	logic take;

	assign divHit = incr && ((div_reg & divMask) == divMask);
	assign take = (state_reg == MPO_IDLE) && (pend_reg != 16'h0000) && enable;

	always_ff @(posedge mclk) begin
		if (rst || !enable) begin
			div_reg <= 2'h0;
		end else if (incr) begin
			div_reg <= div_reg + 2'h1;
		end
	end

	// Pending increments; a new one and a take can meet in the same cycle
	always_ff @(posedge mclk) begin
		if (rst || !enable) begin
			pend_reg <= 16'h0000;
		end else begin
			pend_reg <= pend_reg + 16'(divHit && pend_reg != 16'hFFFF) - 16'(take);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !enable) begin
			state_reg <= MPO_IDLE;
			timer_reg <= 32'h0;
		end else begin
			case (state_reg)
				MPO_IDLE: begin
					if (take) begin
						state_reg <= MPO_ON;
						timer_reg <= pulseCycles - 32'h1;
					end
				end
				MPO_ON: begin
					if (timer_reg == 32'h0) begin
						state_reg <= MPO_GAP;
						timer_reg <= pulseCycles - 32'h1;
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				MPO_GAP: begin
					if (timer_reg == 32'h0) begin
						state_reg <= MPO_IDLE;
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				default: state_reg <= MPO_IDLE;
			endcase
		end
	end

	assign pulseOn = (state_reg == MPO_ON);
endmodule

// ===== logic/mpo_pulse_output.sv
// Top of the meter pulse output unit with Avalon-MM registers
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
module mpo_pulse_output
	import mpo_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] meterType,
	input wire logic heatEnergyIncr,
	input wire logic coolingEnergyIncr,
	input wire logic volumeIncr,
	input wire logic [1:0] nvStoredState,
	output logic [1:0] nvWriteData,
	output logic nvWriteStrobe,
	output logic outFirst,
	output logic outSecond
);
	logic [7:0] pulseDurationCode_reg;
	logic [1:0] ctrlState_reg;
	logic restored_reg;
	logic [3:0] type_reg;
	logic typeLatched_reg;
	logic ack_reg;
	mpo_src_t srcFirst;
	mpo_src_t srcSecond;
	logic [31:0] pulseCycles;
	logic [1:0] divFirst;
	logic controlled;
	logic validCode;
	logic incrFirst;
	logic incrSecond;
	logic pulseFirst;
	logic pulseSecond;
	logic wrCode;
	logic wrCtrl;
	logic access;

	assign access = (avs_read || avs_write) && !ack_reg;
	// Writes land at the edge where waitrequest is seen low
	assign wrCode = avs_write && ack_reg && avs_address == ADDR_CODE && avs_byteenable[0];
	assign wrCtrl = avs_write && ack_reg && avs_address == ADDR_CTRL && avs_byteenable[0];

	// Meter type caught once after reset, then frozen
	always_ff @(posedge mclk) begin
		if (rst) begin
			typeLatched_reg <= 1'b0;
			type_reg <= 4'h0;
		end else if (!typeLatched_reg) begin
			typeLatched_reg <= 1'b1;
			type_reg <= meterType;
		end
	end

	always_comb begin
		case (type_reg)
			4'h1, 4'h2, 4'h4: begin
				srcFirst = MPO_SRC_HEAT;
				srcSecond = MPO_SRC_VOL;
			end
			4'h3, 4'h6: begin
				srcFirst = MPO_SRC_HEAT;
				srcSecond = MPO_SRC_COOL;
			end
			4'h5: begin
				srcFirst = MPO_SRC_COOL;
				srcSecond = MPO_SRC_VOL;
			end
			default: begin
				srcFirst = MPO_SRC_VOL;
				srcSecond = MPO_SRC_VOL;
			end
		endcase
	end

	// Volume divider modes force volume on the first output
	assign incrFirst = (divFirst != 2'h0 || pulseDurationCode_reg == PDC_V1_3MS9) ? volumeIncr :
		(srcFirst == MPO_SRC_HEAT) ? heatEnergyIncr :
		(srcFirst == MPO_SRC_COOL) ? coolingEnergyIncr : volumeIncr;
	// One of three counters per output; one pulse per displayed digit step
	assign incrSecond = (srcSecond == MPO_SRC_HEAT) ? heatEnergyIncr :
		(srcSecond == MPO_SRC_COOL) ? coolingEnergyIncr : volumeIncr;

	// Duration from code; 5, 3.9, 22, 32 and 100 ms
	always_comb begin
		divFirst = 2'h0;
		validCode = 1'b1;
		case (pulseDurationCode_reg)
			PDC_V4_5MS: begin
				pulseCycles = CYC_5MS;
				divFirst = DIV_VOL4;
			end
			PDC_V1_3MS9: pulseCycles = CYC_3M9;
			PDC_V4_22MS: begin
				pulseCycles = CYC_22MS;
				divFirst = DIV_VOL4;
			end
			PDC_100MS: pulseCycles = CYC_100MS;
			PDC_32MS, PDC_CTRL: pulseCycles = CYC_32MS;
			default: begin
				pulseCycles = CYC_32MS;
				validCode = 1'b0;
			end
		endcase
	end

	assign controlled = (pulseDurationCode_reg == PDC_CTRL);

	mpo_channel chanFirst (
		.mclk(mclk),
		.rst(rst),
		.incr(incrFirst),
		.divMask(divFirst),
		.pulseCycles(pulseCycles),
		.enable(!controlled && validCode),
		.pulseOn(pulseFirst)
	);

	mpo_channel chanSecond (
		.mclk(mclk),
		.rst(rst),
		.incr(incrSecond),
		.divMask(2'h0),
		.pulseCycles(pulseCycles),
		.enable(!controlled && validCode),
		.pulseOn(pulseSecond)
	);

	// Code rewritable by software; unlisted codes rejected
	always_ff @(posedge mclk) begin
		if (rst) begin
			pulseDurationCode_reg <= PDC_RESET;
		end else if (wrCode) begin
			case (avs_writedata[7:0])
				PDC_V4_5MS, PDC_V1_3MS9, PDC_V4_22MS, PDC_32MS, PDC_100MS, PDC_CTRL:
					pulseDurationCode_reg <= avs_writedata[7:0];
				default: pulseDurationCode_reg <= pulseDurationCode_reg;
			endcase
		end
	end

	// Restore stored state one cycle after reset, then commands
	always_ff @(posedge mclk) begin
		if (rst) begin
			restored_reg <= 1'b0;
			ctrlState_reg <= 2'h0;
		end else if (!restored_reg) begin
			restored_reg <= 1'b1;
			ctrlState_reg <= nvStoredState;
		end else if (wrCtrl) begin
			ctrlState_reg <= avs_writedata[1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			nvWriteStrobe <= 1'b0;
			nvWriteData <= 2'h0;
		end else begin
			nvWriteStrobe <= restored_reg && wrCtrl && avs_writedata[1:0] != ctrlState_reg;
			nvWriteData <= avs_writedata[1:0];
		end
	end

	// ON closes output, OFF opens it
	always_ff @(posedge mclk) begin
		if (rst) begin
			outFirst <= 1'b0;
			outSecond <= 1'b0;
		end else if (controlled) begin
			outFirst <= ctrlState_reg[0];
			outSecond <= ctrlState_reg[1];
		end else begin
			outFirst <= pulseFirst;
			outSecond <= pulseSecond;
		end
	end

	// Bus slave: one wait cycle, answer on second edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_reg <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_reg <= access;
			avs_waitrequest <= !access;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (access && avs_read) begin
			case (avs_address)
				ADDR_CODE: avs_readdata <= {24'h0, pulseDurationCode_reg};
				ADDR_CTRL: avs_readdata <= {30'h0, ctrlState_reg};
				ADDR_STAT: avs_readdata <= {29'h0, controlled, outSecond, outFirst};
				ADDR_TYPE: avs_readdata <= {28'h0, type_reg};
				default: avs_readdata <= RD_UNMAPPED;
			endcase
		end
	end
endmodule

// ===== verification/mpo_checker_sva.sv
// Port assertions for the meter pulse output unit
module mpo_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic nvWriteStrobe,
	input wire logic outFirst,
	input wire logic outSecond
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("bus request not answered");
	wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low without request");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !outFirst && !outSecond && !nvWriteStrobe)
		else $error("outputs active after reset");
	strobe_single_a: assert property (nvWriteStrobe |=> !nvWriteStrobe)
		else $error("store strobe longer than one cycle");
	strobe_cause_a: assert property (nvWriteStrobe |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("store strobe without write");
	first_hold_a: assert property ($rose(outFirst) |=> outFirst [*8])
		else $error("first output pulse too short");
	second_hold_a: assert property ($rose(outSecond) |=> outSecond [*8])
		else $error("second output pulse too short");
endmodule

bind mpo_pulse_output mpo_checker chk (.mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nvWriteStrobe(nvWriteStrobe),
	.outFirst(outFirst), .outSecond(outSecond));

// ===== verification/mpo_partner.sv
// Model of the external pulse counter and the stored output state
module mpo_partner (
	input wire logic mclk,
	input wire logic outFirst,
	input wire logic [1:0] nvWriteData,
	input wire logic nvWriteStrobe,
	output logic [1:0] nvStoredState,
	output int firstCount
);
	timeunit 1ns;
	timeprecision 1ps;
	logic firstLast = 1'b0;
	initial nvStoredState = 2'h0;
	initial firstCount = 0;
	always @(posedge mclk) begin
		firstLast <= outFirst;
		if (outFirst && !firstLast)
			firstCount <= firstCount + 1;
	end
	always @(posedge mclk) if (nvWriteStrobe) nvStoredState <= nvWriteData;
endmodule

// ===== verification/tb.sv
// Self-checking bench for the meter pulse output unit
module tb
	import mpo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic heat = 1'b0;
	logic cool = 1'b0;
	logic vol = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [3:0] mType = 4'h1;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rdVal = 32'h0;
	logic waitreq, o1, o2, nvStb;
	logic [1:0] nvData;
	logic [1:0] nvState;
	int firstCount;
	int errCount = 0;
	int compares = 0;
	initial forever #2 mclk = ~mclk;
	mpo_pulse_output dut (.mclk(mclk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitreq),
		.meterType(mType), .heatEnergyIncr(heat), .coolingEnergyIncr(cool), .volumeIncr(vol),
		.nvStoredState(nvState), .nvWriteData(nvData), .nvWriteStrobe(nvStb), .outFirst(o1), .outSecond(o2));
	mpo_partner partner (.mclk(mclk), .outFirst(o1), .nvWriteData(nvData), .nvWriteStrobe(nvStb),
		.nvStoredState(nvState), .firstCount(firstCount));
	task stop_test;
		$display("errors %0d compares %0d", errCount, compares);
		if (errCount == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			errCount++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	function automatic logic [31:0] outs();
		return {30'h0, o2, o1};
	endfunction
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (waitreq !== 1'b0) begin
			errCount++;
			stop_test();
		end
		rdVal = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge mclk);
	endtask
	task t_regs;
		bus(1'b0, ADDR_CODE, 32'h0);
		chk("code", 32'h5F, rdVal);
		bus(1'b1, ADDR_CODE, 32'h11);
		bus(1'b0, ADDR_CODE, 32'h0);
		chk("code", 32'h5F, rdVal);
		bus(1'b1, ADDR_TYPE, 32'h5);
		bus(1'b0, ADDR_TYPE, 32'h0);
		chk("type", 32'h1, rdVal);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", RD_UNMAPPED, rdVal);
	endtask
	task t_pulse;
		heat <= 1'b1;
		@(posedge mclk);
		heat <= 1'b0;
		tick(10);
		chk("outs", 32'h1, outs());
		vol <= 1'b1;
		@(posedge mclk);
		vol <= 1'b0;
		tick(10);
		chk("outs", 32'h3, outs());
		chk("count", 32'h1, 32'(firstCount));
	endtask
	task t_codes;
		logic [7:0] codes [5];
		codes = '{PDC_V4_5MS, PDC_V1_3MS9, PDC_V4_22MS, PDC_100MS, PDC_CTRL};
		foreach (codes[i]) begin
			bus(1'b1, ADDR_CODE, {24'h0, codes[i]});
			bus(1'b0, ADDR_CODE, 32'h0);
			chk("code", {24'h0, codes[i]}, rdVal);
		end
	endtask
	task t_ctrl;
		bus(1'b1, ADDR_CTRL, 32'h0);
		tick(4);
		chk("outs", 32'h0, outs());
		bus(1'b1, ADDR_CTRL, 32'h1);
		tick(4);
		chk("outs", 32'h1, outs());
		chk("stored", 32'h1, {30'h0, nvState});
		bus(1'b0, ADDR_STAT, 32'h0);
		chk("status", 32'h5, rdVal);
		tick(10);
		bus(1'b1, ADDR_CTRL, 32'h2);
		heat <= 1'b1;
		@(posedge mclk);
		heat <= 1'b0;
		tick(10);
		chk("outs", 32'h2, outs());
	endtask
	task t_restore;
		rst <= 1'b1;
		mType <= 4'h5;
		tick(6);
		rst <= 1'b0;
		tick(2);
		chk("outs", 32'h0, outs());
		bus(1'b1, ADDR_CODE, {24'h0, PDC_CTRL});
		tick(4);
		chk("outs", 32'h2, outs());
		bus(1'b0, ADDR_STAT, 32'h0);
		chk("status", 32'h6, rdVal);
	endtask
	task t_types;
		mType <= 4'h3;
		tick(4);
		bus(1'b1, ADDR_CODE, {24'h0, PDC_32MS});
		cool <= 1'b1;
		@(posedge mclk);
		cool <= 1'b0;
		tick(10);
		chk("outs", 32'h1, outs());
		bus(1'b0, ADDR_TYPE, 32'h0);
		chk("type", 32'h5, rdVal);
		bus(1'b1, ADDR_CODE, {24'h0, PDC_CTRL});
		tick(10);
		chk("outs", 32'h2, outs());
		bus(1'b1, ADDR_CODE, {24'h0, PDC_V4_5MS});
		vol <= 1'b1;
		tick(3);
		vol <= 1'b0;
		tick(10);
		chk("outs", 32'h2, outs());
		vol <= 1'b1;
		@(posedge mclk);
		vol <= 1'b0;
		tick(10);
		chk("outs", 32'h3, outs());
	endtask
	initial begin
		tick(6);
		rst <= 1'b0;
		tick(2);
		t_regs();
		t_pulse();
		t_codes();
		t_ctrl();
		t_restore();
		t_types();
		stop_test();
	end
endmodule
